// file: verif/ife_optic_model.sv
// Optical transceiver model: photodiode echo of the emitter plus frame and pulse sources.
`timescale 1ns/100ps
module ife_optic_model
  import ife_pkg::*;
#(
  parameter int LAT_CYC = 500
) (
  input wire logic sys_clk,
  input wire logic ir_txd,
  output logic ir_rxd
);
  logic light = 1'b0;
  int quiet = 0;

  // The own emitter saturates the photodiode, so emitted light comes straight back.
  assign ir_rxd = light | ir_txd;

  always @(posedge sys_clk) begin
    quiet <= (ir_txd === 1'b1) ? 0 : quiet + 1;
  end

  // ****************************************************************
  // Sources
  // ****************************************************************
  // Never sends over the far emitter, and leaves it time to recover after sending.
  task automatic wait_turn();
    while (quiet < LAT_CYC) @(posedge sys_clk);
  endtask : wait_turn

  task automatic chip(input logic on);
    light <= on;
    repeat (31) @(posedge sys_clk);
  endtask : chip

  task automatic ppm_frame(input logic [7:0] pairs, input int n, input logic bad);
    wait_turn();
    for (int r = 0; r < PRE_BITS * PRE_REPS; r++) begin
      chip(PREAMBLE_PAT[PRE_TOP - 4'(r % PRE_BITS)]);
    end
    for (int j = 0; j < n; j++) begin
      for (int m = 0; m < SYM_CHIPS; m++) begin
        chip(2'(m) == pairs[7 - 2 * j -: 2]);
      end
    end
    // Two separate pulses in one symbol, since the receiver sees edges, not levels.
    if (bad) begin
      chip(1'b1);
      chip(1'b0);
      chip(1'b1);
      chip(1'b0);
    end
    repeat (12) chip(1'b0);
  endtask : ppm_frame

  task automatic rz_pulse(input int w);
    wait_turn();
    light <= 1'b1;
    repeat (w) @(posedge sys_clk);
    light <= 1'b0;
    @(posedge sys_clk);
  endtask : rz_pulse
endmodule : ife_optic_model

// file: verif/tb_ife_endec.sv
// Self-checking testbench of the infrared endec against the optical transceiver model.
`timescale 1ns/100ps
module tb_ife_endec
  import ife_pkg::*;
;
  logic sys_clk, sys_rst, tx_valid, tx_ready, tx_busy, ir_txd, ir_rxd, rx_uart, rx_valid;
  logic rx_err, rx_locked, link_busy, rate_commit, peer_supports, link_restart;
  logic low_power_v12, ppm_mode;
  logic [1:0] tx_data, rx_data;
  ife_rate_e rate_req, cur_rate;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  ife_endec i_ife_endec (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_busy(tx_busy), .ir_txd(ir_txd),
    .ir_rxd(ir_rxd), .rx_uart(rx_uart), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .rx_locked(rx_locked), .link_busy(link_busy), .rate_req(rate_req),
    .rate_commit(rate_commit), .peer_supports(peer_supports), .link_restart(link_restart),
    .low_power_v12(low_power_v12), .cur_rate(cur_rate), .ppm_mode(ppm_mode));

  ife_optic_model i_ife_optic_model (.sys_clk(sys_clk), .ir_txd(ir_txd), .ir_rxd(ir_rxd));

  always #2 sys_clk = ~sys_clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic commit(input ife_rate_e r, input logic peer, input logic lp);
    @(posedge sys_clk);
    rate_req <= r;
    peer_supports <= peer;
    low_power_v12 <= lp;
    rate_commit <= 1'b1;
    @(posedge sys_clk);
    rate_commit <= 1'b0;
    @(negedge sys_clk);
  endtask : commit

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic rates();
    chk(32'({ir_txd, tx_busy, rx_locked, rx_uart}), 32'h1);
    chk(32'(cur_rate), 32'(RATE_9K6));
    commit(RATE_4M, 1'b0, 1'b0);
    chk(32'(cur_rate), 32'(RATE_9K6));
    commit(RATE_4M, 1'b1, 1'b0);
    chk(32'({cur_rate, ppm_mode}), 32'({RATE_4M, 1'b1}));
    @(posedge sys_clk);
    link_restart <= 1'b1;
    @(posedge sys_clk);
    link_restart <= 1'b0;
    @(negedge sys_clk);
    chk(32'(cur_rate), 32'(RATE_9K6));
    commit(RATE_576K, 1'b1, 1'b1);
    chk(32'(cur_rate), 32'(RATE_9K6));
    commit(RATE_115K2, 1'b1, 1'b1);
    chk(32'({cur_rate, ppm_mode}), 32'({RATE_115K2, 1'b0}));
    commit(RATE_9K6, 1'b1, 1'b0);
    chk(32'(cur_rate), 32'(RATE_9K6));
  endtask : rates

  task automatic slow_tx(input ife_rate_e r, input int bps, input int ovs, input int pls);
    int tick, hi, pulses, bits;
    tick = CLK_HZ / (ovs * bps);
    hi = 0;
    pulses = 0;
    bits = 0;
    commit(r, 1'b1, 1'b0);
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data <= 2'h0;
    for (int n = 0; n < 5 * ovs * tick; n++) begin
      @(negedge sys_clk);
      if (ir_txd === 1'b1) begin
        hi++;
      end else if (hi > 0) begin
        chk(32'(hi >= pls * tick - 2 && hi <= pls * tick + 3), 32'h1);
        pulses++;
        hi = 0;
      end
      if (tx_ready === 1'b1) bits++;
      @(posedge sys_clk);
      tx_data <= {1'b0, bits == 1};
      tx_valid <= bits < 3;
    end
    chk(32'(pulses), 32'h2);
  endtask : slow_tx

  task automatic slow_rx(input ife_rate_e r, input int bps, input int ovs, input int str);
    int tick, lo;
    tick = CLK_HZ / (ovs * bps);
    lo = 0;
    commit(r, 1'b1, 1'b0);
    fork
      i_ife_optic_model.rz_pulse(50);
      for (int n = 0; n < 600 + (str + 2) * tick; n++) begin
        @(negedge sys_clk);
        if (rx_uart === 1'b0) lo++;
      end
    join
    chk(32'(lo >= (str - 1) * tick && lo <= (str + 1) * tick + 1), 32'h1);
  endtask : slow_rx

  task automatic ppm_tx();
    int k, t0, idx;
    logic exp;
    logic [7:0] pairs;
    pairs = 8'h1b;
    k = 0;
    t0 = -1;
    idx = 0;
    commit(RATE_4M, 1'b1, 1'b0);
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data <= pairs[7:6];
    for (int n = 0; n < 10000 && k < 272; n++) begin
      @(negedge sys_clk);
      if (t0 < 0 && tx_busy === 1'b1) t0 = n;
      chk(32'({rx_locked, rx_valid}), 32'h0);
      if (t0 >= 0 && n - t0 == (125 * k) / 4 + 15) begin
        if (k < 256) exp = PREAMBLE_PAT[PRE_TOP - 4'(k % PRE_BITS)];
        else exp = 2'(k % 4) == pairs[7 - 2 * ((k - 256) / 4) -: 2];
        chk(32'(ir_txd), 32'(exp));
        k++;
      end
      if (tx_ready === 1'b1) idx++;
      @(posedge sys_clk);
      tx_valid <= idx < 4;
      if (idx < 4) tx_data <= pairs[7 - 2 * idx -: 2];
    end
    chk(32'(k), 32'd272);
  endtask : ppm_tx

  task automatic ppm_rx(input logic bad);
    int got, errs;
    logic seen;
    logic [7:0] pairs;
    pairs = 8'hd8;
    got = 0;
    errs = 0;
    seen = 1'b0;
    fork
      i_ife_optic_model.ppm_frame(pairs, 4, bad);
      for (int n = 0; n < 12000; n++) begin
        @(negedge sys_clk);
        if (rx_locked === 1'b1) seen = 1'b1;
        if (rx_valid === 1'b1) begin
          chk(32'(seen), 32'h1);
          if (got < 4 && !bad) chk(32'(rx_data), 32'(pairs[7 - 2 * got -: 2]));
          got++;
        end
        if (rx_err === 1'b1) errs++;
      end
    join
    if (!bad) chk(32'(got), 32'h4);
    chk(32'(errs), 32'(bad));
  endtask : ppm_rx

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    tx_valid = 1'b0;
    tx_data = 2'h0;
    rate_req = RATE_9K6;
    rate_commit = 1'b0;
    peer_supports = 1'b0;
    link_restart = 1'b0;
    low_power_v12 = 1'b0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rates();
    slow_tx(RATE_115K2, BPS_115K2, SIR_OVS, SIR_PULSE);
    slow_rx(RATE_115K2, BPS_115K2, SIR_OVS, SIR_STRETCH);
    slow_tx(RATE_1M152, BPS_1M152, MIR_OVS, MIR_PULSE);
    ppm_tx();
    ppm_rx(1'b0);
    ppm_rx(1'b1);
    stop_test();
  end
endmodule : tb_ife_endec

// file: verilog/ife_endec.sv
// Infrared endec: rate negotiation, return-to-zero and four-position codecs.
// Behaviour
// - Links start at base rate, rise after both agree
// - Base rate is always an allowed rate
// - Highest rate uses pulse position coding
// - Two bits form one four-chip symbol
// - One pulse per symbol, position from pair
// - Decoder recovers pair from pulse position
// - Send sixteen repeats of preamble first
// - Receiver locks on preamble before decoding
// - Rate selects return-to-zero or position coding
// - Receiver ready well within latency after sending
// - Old low-power option caps rate at 115k
// - Zero bits are short pulses at slow rates
// - Three-tick transmit pulse, sixteen-tick receive stretch
// - Intermediate rates use quarter-bit pulses
// - Half duplex: receiver ignored while sending
`timescale 1ns/100ps
module ife_endec
  import ife_pkg::*;
#(
  parameter logic [7:0] LOCAL_CAPS = 8'hff
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic tx_valid,
  input wire logic [1:0] tx_data,
  output logic tx_ready,
  output logic tx_busy,
  output logic ir_txd,
  input wire logic ir_rxd,
  output logic rx_uart,
  output logic rx_valid,
  output logic [1:0] rx_data,
  output logic rx_err,
  output logic rx_locked,
  output logic link_busy,
  input wire ife_rate_e rate_req,
  input wire logic rate_commit,
  input wire logic peer_supports,
  input wire logic link_restart,
  input wire logic low_power_v12,
  output ife_rate_e cur_rate,
  output logic ppm_mode
);

  // ****************************************************************
  // Pin synchroniser and mode decode
  // ****************************************************************
  logic rxd_meta, rxd_s, rxd_d, rx_edge;
  logic tick, tick_restart, sir_mode, rx_enabled;
  logic [4:0] bit_last, pulse_w, stretch_len;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_meta <= 1'b0;
      rxd_s <= 1'b0;
      rxd_d <= 1'b0;
    end else begin
      rxd_meta <= ir_rxd;
      rxd_s <= rxd_meta;
      rxd_d <= rxd_s;
    end
  end

  assign rx_edge = rxd_s & ~rxd_d;
  assign ppm_mode = (cur_rate == RATE_4M);
  assign sir_mode = (cur_rate <= RATE_115K2);
  assign bit_last = ppm_mode ? 5'(SYM_CHIPS - 1) : sir_mode ? 5'(SIR_OVS - 1) : 5'(MIR_OVS - 1);
  assign pulse_w = sir_mode ? 5'(SIR_PULSE) : 5'(MIR_PULSE);
  assign stretch_len = sir_mode ? 5'(SIR_STRETCH) : 5'(MIR_STRETCH);

  // Tick is the chip strobe at the highest rate, else the oversampling strobe.
  ife_tick_gen u_tick (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(tick_restart),
    .step(ife_rate_step(cur_rate)),
    .tick(tick)
  );

  // ****************************************************************
  // Rate negotiation
  // ****************************************************************
  ife_rate_e next_rate;
  logic [7:0] caps_eff;
  logic rate_take;

  always_comb begin
    caps_eff = (LOCAL_CAPS | CAPS_BASE) & (low_power_v12 ? CAPS_LOW_POWER : CAPS_ALL);
    rate_take = rate_commit && peer_supports && caps_eff[rate_req] && !link_busy;
    next_rate = cur_rate;
    if (link_restart) begin
      next_rate = RATE_9K6;
    end else if (rate_take) begin
      next_rate = rate_req;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_rate <= RATE_9K6;
    end else begin
      cur_rate <= next_rate;
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  ife_tx_e tx_st, next_tx_st;
  logic [4:0] tx_tcnt, next_tcnt;
  logic [7:0] pre_idx, next_pre;
  logic [1:0] tx_pair, next_pair;
  logic [3:0] tx_sym, next_sym;
  logic [8:0] blank, next_blank;
  logic next_txd, load;

  always_comb begin
    next_tx_st = tx_st;
    next_tcnt = tx_tcnt;
    next_pre = pre_idx;
    next_pair = tx_pair;
    next_blank = (blank != 9'h0) ? 9'(blank - 9'h1) : 9'h0;
    tx_ready = 1'b0;
    load = 1'b0;
    case (tx_st)
      TX_IDLE: begin
        if (tx_valid && !link_busy && blank == 9'h0) begin
          next_tx_st = ppm_mode ? TX_PRE : TX_DATA;
          next_pre = 8'h0;
          next_tcnt = bit_last;
          next_pair = 2'h3;
        end
      end
      TX_PRE: begin
        if (tick) begin
          if (pre_idx == PRE_LAST) begin
            next_tx_st = TX_DATA;
            load = 1'b1;
          end else begin
            next_pre = 8'(pre_idx + 8'h1);
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          if (tx_tcnt == bit_last) begin
            load = 1'b1;
          end else begin
            next_tcnt = 5'(tx_tcnt + 5'h1);
          end
        end
      end
      default: begin
        next_tx_st = TX_IDLE;
      end
    endcase
    if (load) begin
      next_tcnt = 5'h0;
      if (tx_valid) begin
        tx_ready = 1'b1;
        next_pair = tx_data;
      end else begin
        next_tx_st = TX_IDLE;
        next_blank = 9'(TURN_CYC);
      end
    end
    tx_sym = 4'(4'h8 >> tx_pair);
    next_sym = 4'(4'h8 >> next_pair);
    case (next_tx_st)
      TX_PRE: next_txd = PREAMBLE_PAT[PRE_TOP - next_pre[3:0]];
      TX_DATA: next_txd = ppm_mode ? next_sym[SYM_TOP - next_tcnt[1:0]]
                                   : (!next_pair[0] && next_tcnt < pulse_w);
      default: next_txd = 1'b0;
    endcase
  end

  assign tick_restart = (tx_st == TX_IDLE) && (next_tx_st != TX_IDLE);
  assign tx_busy = (tx_st != TX_IDLE);
  assign rx_enabled = (tx_st == TX_IDLE) && (blank == 9'h0);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st <= TX_IDLE;
      tx_tcnt <= 5'h0;
      pre_idx <= 8'h0;
      tx_pair <= 2'h3;
      blank <= 9'h0;
      ir_txd <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_tcnt <= next_tcnt;
      pre_idx <= next_pre;
      tx_pair <= next_pair;
      blank <= next_blank;
      ir_txd <= next_txd;
    end
  end

  // ****************************************************************
  // Receivers: pulse stretcher and four-position decoder
  // ****************************************************************
  ife_rx_e rx_st, next_rx_st;
  logic [4:0] stretch, next_stretch;
  logic [5:0] rx_cnt, next_cnt;
  logic [15:0] rx_chips, next_chips, win;
  logic [1:0] sph, next_sph, grp, next_grp, fcnt, next_fcnt;
  logic rx_seen, next_seen, chip_end, chip_val;
  logic next_rx_valid, next_rx_err;
  logic [1:0] next_rx_data;
  logic [2:0] dec_old, dec_top, dec_low;

  // Returns {legal, pair} for a four-chip symbol.
  function automatic logic [2:0] ife_decode(logic [3:0] c);
    case (c)
      4'h8: return 3'h4;
      4'h4: return 3'h5;
      4'h2: return 3'h6;
      4'h1: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction : ife_decode

  always_comb begin
    next_stretch = stretch;
    if (!ppm_mode && rx_enabled && rx_edge && stretch == 5'h0) begin
      next_stretch = stretch_len;
    end else if (stretch != 5'h0 && tick) begin
      next_stretch = 5'(stretch - 5'h1);
    end
    next_rx_st = rx_st;
    next_cnt = rx_cnt;
    next_seen = rx_seen;
    next_chips = rx_chips;
    next_sph = sph;
    next_grp = grp;
    next_fcnt = fcnt;
    next_rx_valid = 1'b0;
    next_rx_err = 1'b0;
    next_rx_data = rx_data;
    chip_end = 1'b0;
    chip_val = 1'b0;
    win = {rx_chips[14:0], 1'b0};
    dec_old = ife_decode(rx_chips[15:12]);
    dec_top = 3'h0;
    dec_low = 3'h0;
    if (!(ppm_mode && rx_enabled)) begin
      next_rx_st = RX_HUNT;
      next_cnt = 6'h0;
      next_seen = 1'b0;
    end else if (rx_st == RX_FLUSH) begin
      {next_rx_valid, next_rx_data} = dec_old;
      next_rx_err = !dec_old[2];
      next_chips = {rx_chips[11:0], 4'h0};
      next_fcnt = 2'(fcnt - 2'h1);
      if (fcnt == 2'h0) begin
        next_rx_st = RX_HUNT;
      end
    end else begin
      // Each pulse realigns the chip timer, so drift builds over at most the seven empty chips of the preamble.
      if (rx_edge) begin
        if (rx_cnt > CHIP_HALF) begin
          chip_end = 1'b1;
          chip_val = rx_seen;
        end
        next_seen = 1'b1;
        next_cnt = 6'h1;
      end else if (rx_cnt == CHIP_END) begin
        chip_end = 1'b1;
        chip_val = rx_seen;
        next_seen = 1'b0;
        next_cnt = 6'h0;
      end else begin
        next_cnt = 6'(rx_cnt + 6'h1);
      end
      if (chip_end) begin
        win = {rx_chips[14:0], chip_val};
        next_chips = win;
        dec_top = ife_decode(win[15:12]);
        dec_low = ife_decode(win[3:0]);
        next_sph = 2'(sph + 2'h1);
        case (rx_st)
          RX_HUNT: begin
            if (win == PREAMBLE_PAT) begin
              next_rx_st = RX_PRE;
              next_sph = 2'h0;
              next_grp = 2'h0;
            end
          end
          RX_PRE, RX_DATA: begin
            if (sph == SYM_TOP) begin
              next_grp = 2'(grp + 2'h1);
              if (rx_st == RX_DATA || (grp == SYM_TOP && win != PREAMBLE_PAT)) begin
                next_rx_st = RX_DATA;
                if (win[3:0] == 4'h0) begin
                  next_rx_st = RX_FLUSH;
                  next_fcnt = 2'h2;
                end else if (!dec_low[2]) begin
                  next_rx_err = 1'b1;
                  next_rx_st = RX_HUNT;
                end else begin
                  {next_rx_valid, next_rx_data} = dec_top;
                  next_rx_err = !dec_top[2];
                  if (next_rx_err) begin
                    next_rx_st = RX_HUNT;
                  end
                end
              end
            end
          end
          default: begin
            next_rx_st = RX_HUNT;
          end
        endcase
      end
    end
  end

  assign rx_locked = (rx_st != RX_HUNT);
  assign link_busy = rx_locked || (stretch != 5'h0);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stretch <= 5'h0;
      rx_uart <= 1'b1;
      rx_st <= RX_HUNT;
      rx_cnt <= 6'h0;
      rx_seen <= 1'b0;
      rx_chips <= 16'h0;
      sph <= 2'h0;
      grp <= 2'h0;
      fcnt <= 2'h0;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      rx_data <= 2'h0;
    end else begin
      stretch <= next_stretch;
      rx_uart <= (next_stretch == 5'h0);
      rx_st <= next_rx_st;
      rx_cnt <= next_cnt;
      rx_seen <= next_seen;
      rx_chips <= next_chips;
      sph <= next_sph;
      grp <= next_grp;
      fcnt <= next_fcnt;
      rx_valid <= next_rx_valid;
      rx_err <= next_rx_err;
      rx_data <= next_rx_data;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam logic [7:0] SYM_MIN_GAP = 8'(SYM_CHIPS * CHIP_CYC - 4);
  logic [7:0] rdy_gap;
  logic [4:0] low_ticks;
  logic in_pre;

  assign in_pre = (tx_st == TX_PRE);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_gap <= 8'hff;
      low_ticks <= 5'h0;
    end else begin
      rdy_gap <= tx_ready ? 8'h0 : (rdy_gap == 8'hff ? rdy_gap : 8'(rdy_gap + 8'h1));
      low_ticks <= rx_uart ? 5'h0 : 5'(low_ticks + {4'h0, tick});
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_tick_quiet;
    ##1 (!tick) [*8];
  endsequence

  a_rate_restart_base: assert property (link_restart |=> cur_rate == RATE_9K6)
    else $error("rate did not return to base after restart");
  a_rate_needs_peer: assert property ($changed(cur_rate) && cur_rate != RATE_9K6
    |-> $past(peer_supports))
    else $error("rate rose without peer support");
  a_base_rate_kept: assert property (rate_commit && peer_supports && rate_req == RATE_9K6
    && !link_busy |=> cur_rate == RATE_9K6)
    else $error("base rate refused");
  a_low_power_cap: assert property ($past(low_power_v12) && $changed(cur_rate)
    |-> cur_rate <= RATE_115K2)
    else $error("low power option exceeded 115k");
  a_ppm_only_4m: assert property (in_pre || (tx_busy && ppm_mode) |-> cur_rate == RATE_4M)
    else $error("position coding outside highest rate");
  a_ppm_onehot: assert property (tx_st == TX_DATA && ppm_mode |-> $onehot(tx_sym))
    else $error("symbol without exactly one pulse");
  a_sym_period: assert property (ppm_mode && tx_ready |-> rdy_gap >= SYM_MIN_GAP)
    else $error("symbol shorter than four chips");
  a_pre_length: assert property ($fell(in_pre) |-> $past(pre_idx) == PRE_LAST)
    else $error("preamble cut short");
  a_lock_first: assert property (rx_valid |-> $past(rx_locked))
    else $error("data decoded before lock");
  a_chip_strobe: assert property (tick && ppm_mode && tx_busy
    |-> s_tick_quiet ##[23:24] tick)
    else $error("chip strobe period wrong");
  a_sir_pulse_slot: assert property (ir_txd && !ppm_mode |-> tx_tcnt < pulse_w)
    else $error("slow pulse too wide");
  a_rx_stretch: assert property ($rose(rx_uart) && sir_mode && $past(sir_mode)
    |-> low_ticks == 5'(SIR_STRETCH))
    else $error("receive stretch not sixteen ticks");
  a_half_duplex: assert property (tx_busy |-> rx_uart && !rx_valid && !rx_locked)
    else $error("receiver active while sending");
  a_rx_latency: assert property ($fell(tx_busy) |-> ##[1:300] rx_enabled)
    else $error("receiver not ready after sending");

endmodule : ife_endec

// file: verilog/ife_pkg.sv
// Constants, types and rate table shared by the infrared four-position endec.
package ife_pkg;

  // ****************************************************************
  // Clock and chip timing
  // ****************************************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_MHZ = 250;
  localparam int CHIP_NS = 125;
  localparam int CHIP_CYC = CHIP_NS * CLK_MHZ / 1000;
  localparam logic [5:0] CHIP_END = 6'(CHIP_CYC - 1);
  localparam logic [5:0] CHIP_HALF = 6'(CHIP_CYC / 2);
  localparam int SYM_CHIPS = 4;
  localparam logic [1:0] SYM_TOP = 2'(SYM_CHIPS - 1);

  // ****************************************************************
  // Preamble
  // ****************************************************************
  localparam int PRE_BITS = 16;
  localparam int PRE_REPS = 16;
  localparam logic [15:0] PREAMBLE_PAT = 16'h80a8;
  localparam logic [3:0] PRE_TOP = 4'(PRE_BITS - 1);
  localparam logic [7:0] PRE_LAST = 8'(PRE_BITS * PRE_REPS - 1);

  // ****************************************************************
  // Return-to-zero pulse shaping, in ticks of the oversampling strobe
  // ****************************************************************
  localparam int SIR_OVS = 16;
  localparam int SIR_PULSE = 3;
  localparam int SIR_STRETCH = 16;
  localparam int MIR_OVS = 4;
  localparam int MIR_PULSE = 1;
  localparam int MIR_STRETCH = 4;

  // ****************************************************************
  // Turnaround
  // ****************************************************************
  localparam int TURN_NS = 1000;
  localparam int TURN_CYC = (TURN_NS * CLK_MHZ + 999) / 1000;
  localparam int LATENCY_MS = 10;

  // ****************************************************************
  // Rates
  // ****************************************************************
  localparam int BPS_9K6 = 9600;
  localparam int BPS_19K2 = 19200;
  localparam int BPS_38K4 = 38400;
  localparam int BPS_57K6 = 57600;
  localparam int BPS_115K2 = 115200;
  localparam int BPS_576K = 576000;
  localparam int BPS_1M152 = 1152000;
  localparam int CHIP_HZ = 8_000_000;

  typedef enum logic [2:0] {
    RATE_9K6 = 3'h0, RATE_19K2 = 3'h1, RATE_38K4 = 3'h2, RATE_57K6 = 3'h3,
    RATE_115K2 = 3'h4, RATE_576K = 3'h5, RATE_1M152 = 3'h6, RATE_4M = 3'h7
  } ife_rate_e;

  localparam logic [7:0] CAPS_BASE = 8'h01;
  localparam logic [7:0] CAPS_LOW_POWER = 8'h1f;
  localparam logic [7:0] CAPS_ALL = 8'hff;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1, TX_PRE = 3'h2, TX_DATA = 3'h4
  } ife_tx_e;

  typedef enum logic [3:0] {
    RX_HUNT = 4'h1, RX_PRE = 4'h2, RX_DATA = 4'h4, RX_FLUSH = 4'h8
  } ife_rx_e;

  // Tick rate per line rate: 16x bit rate, 4x bit rate, or the chip rate.
  function automatic logic [31:0] ife_rate_step(ife_rate_e r);
    case (r)
      RATE_9K6: return 32'(SIR_OVS * BPS_9K6);
      RATE_19K2: return 32'(SIR_OVS * BPS_19K2);
      RATE_38K4: return 32'(SIR_OVS * BPS_38K4);
      RATE_57K6: return 32'(SIR_OVS * BPS_57K6);
      RATE_115K2: return 32'(SIR_OVS * BPS_115K2);
      RATE_576K: return 32'(MIR_OVS * BPS_576K);
      RATE_1M152: return 32'(MIR_OVS * BPS_1M152);
      default: return 32'(CHIP_HZ);
    endcase
  endfunction : ife_rate_step

endpackage : ife_pkg

// file: verilog/ife_tick_gen.sv
// Fractional divider that turns the device clock into a one-cycle tick.
`timescale 1ns/100ps
module ife_tick_gen
  import ife_pkg::*;
#(
  parameter logic [31:0] MODULUS = 32'(CLK_HZ)
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic [31:0] step,
  output logic tick
);

  logic [31:0] acc;
  logic [31:0] next_acc;
  logic next_tick;
  logic [32:0] sum;

  // ****************************************************************
  // Phase accumulator
  // ****************************************************************
  always_comb begin
    sum = {1'b0, acc} + {1'b0, step};
    next_tick = 1'b0;
    next_acc = sum[31:0];
    if (restart) begin
      next_acc = 32'h0;
    end else if (sum >= {1'b0, MODULUS}) begin
      next_acc = 32'(sum - {1'b0, MODULUS});
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= 32'h0;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
    end
  end

endmodule : ife_tick_gen
